// ===== core/emgsr_pkg.sv
// Constants and types shared by the external memory global status and reset block.
// Assumes a single 10 MHz clock domain and a 16-bit I/O-mapped register port.
package emgsr_pkg;

	// ----------------------------------------------------------------------
	// Register port
	// ----------------------------------------------------------------------
	localparam int REG_ADDR_W = 2;
	localparam int REG_DATA_W = 16;
	localparam logic [REG_ADDR_W-1:0] GLOBAL_CTRL_IDX = 2'h0;
	localparam logic [REG_ADDR_W-1:0] SOFT_RESET_IDX = 2'h1;
	localparam logic [REG_ADDR_W-1:0] ERR_STATUS_IDX = 2'h2;

	// ----------------------------------------------------------------------
	// Field layouts and reset values
	// ----------------------------------------------------------------------
	localparam int CTRL_REQ_PIN_BIT = 2;
	localparam int CTRL_GRANT_PIN_BIT = 1;
	localparam int CTRL_REQ_DIS_BIT = 0;
	// Writable configuration bits kept in the control register (10:9, 7, 5, 4).
	localparam logic [REG_DATA_W-1:0] CTRL_CFG_MASK = 16'h06B0;
	localparam logic [REG_DATA_W-1:0] CTRL_RESET = 16'h0000;
	localparam logic [REG_DATA_W-1:0] ERR_RESET = 16'h0000;
	localparam int ERR_TIME_BIT = 12;
	localparam int ERR_SPACE_LSB = 7;
	localparam int ERR_DMA_BIT = 6;
	localparam int ERR_FB_BIT = 5;
	localparam int ERR_EB_BIT = 4;
	localparam int ERR_DB_BIT = 3;
	localparam int ERR_CB_BIT = 2;
	localparam int ERR_PB_BIT = 0;

	// ----------------------------------------------------------------------
	// Requesters and chip-select spaces
	// ----------------------------------------------------------------------
	localparam int NUM_REQ = 6;
	localparam int NUM_SPACE = 4;
	localparam int SRC_W = 3;
	localparam int SPACE_W = 2;
	localparam logic [SRC_W-1:0] SRC_PB = 3'h0;
	localparam logic [SRC_W-1:0] SRC_CB = 3'h1;
	localparam logic [SRC_W-1:0] SRC_DB = 3'h2;
	localparam logic [SRC_W-1:0] SRC_EB = 3'h3;
	localparam logic [SRC_W-1:0] SRC_FB = 3'h4;
	localparam logic [SRC_W-1:0] SRC_DMA = 3'h5;

	// ----------------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int TIMEOUT_NS = 12800;
	localparam int TIMEOUT_CYC = TIMEOUT_NS / CLK_PERIOD_NS;
	localparam int HOLD_W = 4;

	typedef enum logic [1:0] {ST_IDLE, ST_STROBE, ST_HOLD, ST_BUSHELD} emgsr_state_t;

endpackage : emgsr_pkg

// ===== core/emgsr_sync.sv
// Two-flop synchroniser for pin levels entering the ref_clk domain.
// Assumes the inputs are asynchronous levels; pulses shorter than a cycle may be lost.
`timescale 1ns/1ns
module emgsr_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1_r;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			stage1_r <= RST_VAL;
			syncOut <= RST_VAL;
		end else begin
			stage1_r <= asyncIn;
			syncOut <= stage1_r;
		end
	end
endmodule : emgsr_sync

// ===== core/emgsr_core.sv
// Global housekeeping of the external memory interface: control and status,
// soft reset, bus error capture and the access sequencer they act on.
// Assumes pins are asynchronous and registers are reached over a 16-bit I/O port.
//
// Behaviour
// - Control bit 2 shows live request pin.
// - Control bit 1 shows grant pin level.
// - Control bit 0 set blocks all bus grants.
// - Soft reset write clears sequencer and pending requests.
// - Soft reset leaves configuration values untouched.
// - Soft reset register is write-only, 16 bits.
// - Error register captures asynchronous access time-outs.
// - Write to 8-bit asynchronous space is error.
// - Error ends access, runs programmed hold cycles.
// - DMA error flushes all pending DMA requests.
// - Error sets chip-select space bit 10..7.
// - Error sets requester bit 6..2 or 0.
// - Time-out also sets bit 12.
// - Long write error sets only E-bus bit.
// - Long read error sets only D-bus bit.
// - Dual access may set either or both bits.
// - Reading error register clears it.
// - Later errors OR into held bits.
// - CPU-bus error raises bus-error interrupt request.
// - DMA time-out signals DMA, not CPU.
`timescale 1ns/1ns
module emgsr_core
	import emgsr_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [REG_ADDR_W-1:0] regAddr,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [REG_DATA_W-1:0] regWdata,
	output logic [REG_DATA_W-1:0] regRdata,
	input wire logic accValid,
	input wire logic [SRC_W-1:0] accSrc,
	input wire logic [SPACE_W-1:0] accSpace,
	input wire logic accWrite,
	output logic [NUM_REQ-1:0] pendVec,
	output logic accRefused,
	output logic accDone,
	output logic accErr,
	input wire logic [NUM_SPACE-1:0] space8Async,
	input wire logic [HOLD_W-1:0] holdCycles,
	input wire logic extBusReqN,
	input wire logic memReady,
	output logic extBusGrantN,
	output logic extStrobe,
	output logic [SPACE_W-1:0] extSpace,
	output logic extWrite,
	output logic [REG_DATA_W-1:0] cfgBits,
	output logic busErrIrq,
	output logic dmaTimeout
);

	// ----------------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------------
	localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);
	// One counter serves both the strobe time-out and the hold count.
	localparam int CNT_W = (TO_W > HOLD_W) ? TO_W : HOLD_W;

	if (TIMEOUT_CYCLES < 2 || TIMEOUT_CYCLES > 65535) begin : gTimeoutCheck
		$error("TIMEOUT_CYCLES must lie between 2 and 65535");
	end

	// ----------------------------------------------------------------------
	// Pin synchronisation
	// ----------------------------------------------------------------------
	logic [1:0] pinSync;
	logic busReqNSync;
	logic readySync;

	// Request idles high; ready idles low so no access completes early.
	emgsr_sync #(
		.WIDTH(2),
		.RST_VAL(2'b01)
	) uPinSync (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.asyncIn({memReady, extBusReqN}),
		.syncOut(pinSync)
	);
	assign busReqNSync = pinSync[0];
	assign readySync = pinSync[1];

	// ----------------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------------
	logic ctrlWr;
	logic softRst;
	logic errRd;
	logic reqDisable_r;
	logic [REG_DATA_W-1:0] cfgStore_r;
	logic [REG_DATA_W-1:0] errStatus_r;
	logic [REG_DATA_W-1:0] errStatus_nxt;
	logic [REG_DATA_W-1:0] errSet;
	logic [REG_DATA_W-1:0] ctrlView;

	assign ctrlWr = regWrEn && (regAddr == GLOBAL_CTRL_IDX);
	// Any data value triggers the soft reset; nothing is stored.
	assign softRst = regWrEn && (regAddr == SOFT_RESET_IDX);
	assign errRd = regRdEn && (regAddr == ERR_STATUS_IDX);

	// Configuration lives only here and ignores the soft reset.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			reqDisable_r <= CTRL_RESET[CTRL_REQ_DIS_BIT];
			cfgStore_r <= CTRL_RESET;
		end else if (ctrlWr) begin
			reqDisable_r <= regWdata[CTRL_REQ_DIS_BIT];
			cfgStore_r <= regWdata & CTRL_CFG_MASK;
		end
	end

	always_comb begin
		ctrlView = cfgStore_r;
		ctrlView[CTRL_REQ_PIN_BIT] = busReqNSync;
		ctrlView[CTRL_GRANT_PIN_BIT] = extBusGrantN;
		ctrlView[CTRL_REQ_DIS_BIT] = reqDisable_r;
	end

	// Read data is registered: it appears one cycle after the read strobe.
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			regRdata <= 16'h0000;
		end else if (regRdEn) begin
			unique case (regAddr)
				GLOBAL_CTRL_IDX: regRdata <= ctrlView;
				ERR_STATUS_IDX: regRdata <= errStatus_r;
				// The soft reset register cannot be read; it returns zero.
				default: regRdata <= 16'h0000;
			endcase
		end
	end

	assign cfgBits = cfgStore_r;

	// ----------------------------------------------------------------------
	// Pending request slots
	// ----------------------------------------------------------------------
	emgsr_state_t state_r;
	logic [NUM_REQ-1:0] pendValid_r;
	logic [SPACE_W-1:0] pendSpace_r [NUM_REQ];
	logic pendWrite_r [NUM_REQ];
	logic startAcc;
	logic [SRC_W-1:0] pickIdx;
	logic anyPend;
	logic dmaFlush;

	// One slot per requester; a long access is one request in one slot, while
	// a dual access arrives as two requests in two slots.
	for (genvar i = 0; i < NUM_REQ; i++) begin : gSlot
		logic hit;
		assign hit = accValid && (accSrc == SRC_W'(i)) && !pendValid_r[i];
		always_ff @(posedge ref_clk) begin
			if (!nrst) begin
				pendValid_r[i] <= 1'b0;
				pendSpace_r[i] <= '0;
				pendWrite_r[i] <= 1'b0;
			end else if (softRst) begin
				pendValid_r[i] <= 1'b0;
			end else if (hit) begin
				pendValid_r[i] <= 1'b1;
				pendSpace_r[i] <= accSpace;
				pendWrite_r[i] <= accWrite;
			end else if (startAcc && pickIdx == SRC_W'(i)) begin
				pendValid_r[i] <= 1'b0;
			end else if (dmaFlush && SRC_W'(i) == SRC_DMA) begin
				pendValid_r[i] <= 1'b0;
			end
		end
	end

	assign pendVec = pendValid_r;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			accRefused <= 1'b0;
		end else begin
			accRefused <= accValid && (softRst || accSrc >= SRC_W'(NUM_REQ)
				|| pendValid_r[accSrc]);
		end
	end

	// Lowest index wins: the program bus first, the DMA controller last.
	always_comb begin
		pickIdx = '0;
		anyPend = 1'b0;
		for (int k = NUM_REQ - 1; k >= 0; k--) begin
			if (pendValid_r[k]) begin
				pickIdx = SRC_W'(k);
				anyPend = 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------------
	// Access sequencer
	// ----------------------------------------------------------------------
	logic [SRC_W-1:0] curSrc_r;
	logic [CNT_W-1:0] cnt_r;
	logic grantOk;
	logic badWrite;
	logic timeoutHit;
	logic errEv;
	logic errTime;

	assign grantOk = !busReqNSync && !reqDisable_r;
	assign badWrite = pendWrite_r[pickIdx] && space8Async[pendSpace_r[pickIdx]];
	// A grant is taken only from idle, so an access under way finishes unless a soft reset aborts it.
	assign startAcc = (state_r == ST_IDLE) && !softRst && !grantOk && anyPend;
	assign timeoutHit = (state_r == ST_STROBE) && !readySync
		&& (cnt_r == CNT_W'(TIMEOUT_CYCLES - 1));
	assign errEv = !softRst && ((startAcc && badWrite) || timeoutHit);
	assign errTime = timeoutHit;
	assign dmaFlush = errEv && ((startAcc ? pickIdx : curSrc_r) == SRC_DMA);

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state_r <= ST_IDLE;
			curSrc_r <= '0;
			cnt_r <= '0;
			extSpace <= '0;
			extWrite <= 1'b0;
		end else if (softRst) begin
			state_r <= ST_IDLE;
			cnt_r <= '0;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					cnt_r <= '0;
					if (grantOk) begin
						state_r <= ST_BUSHELD;
					end else if (anyPend) begin
						curSrc_r <= pickIdx;
						extSpace <= pendSpace_r[pickIdx];
						extWrite <= pendWrite_r[pickIdx];
						// An unsupported write never drives a strobe.
						state_r <= badWrite ? ST_HOLD : ST_STROBE;
					end
				end
				ST_STROBE: begin
					if (readySync || timeoutHit) begin
						state_r <= ST_HOLD;
						cnt_r <= '0;
					end else begin
						cnt_r <= cnt_r + CNT_W'(1);
					end
				end
				ST_HOLD: begin
					if (cnt_r >= CNT_W'(holdCycles)) begin
						state_r <= ST_IDLE;
						cnt_r <= '0;
					end else begin
						cnt_r <= cnt_r + CNT_W'(1);
					end
				end
				ST_BUSHELD: begin
					if (busReqNSync || reqDisable_r) begin
						state_r <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------------
	// Pin and completion outputs
	// ----------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			extBusGrantN <= 1'b1;
			extStrobe <= 1'b0;
			accDone <= 1'b0;
			accErr <= 1'b0;
		end else begin
			extBusGrantN <= !(state_r == ST_IDLE && grantOk && !softRst)
				&& !(state_r == ST_BUSHELD && !busReqNSync && !reqDisable_r
				&& !softRst);
			extStrobe <= !softRst && ((startAcc && !badWrite)
				|| (state_r == ST_STROBE && !readySync && !timeoutHit));
			accDone <= !softRst && state_r == ST_HOLD && cnt_r >= CNT_W'(holdCycles);
			accErr <= errEv;
		end
	end

	// ----------------------------------------------------------------------
	// Error status capture
	// ----------------------------------------------------------------------
	logic [SRC_W-1:0] errSrc;
	logic [SPACE_W-1:0] errSpace;

	assign errSrc = startAcc ? pickIdx : curSrc_r;
	assign errSpace = startAcc ? pendSpace_r[pickIdx] : extSpace;

	always_comb begin
		errSet = 16'h0000;
		if (errEv) begin
			errSet[ERR_SPACE_LSB + int'(errSpace)] = 1'b1;
			// Each slot owns one requester bit, so a long access marks only its
			// own bus and a dual access marks whichever of its two slots failed.
			unique case (errSrc)
				SRC_PB: errSet[ERR_PB_BIT] = 1'b1;
				SRC_CB: errSet[ERR_CB_BIT] = 1'b1;
				SRC_DB: errSet[ERR_DB_BIT] = 1'b1;
				SRC_EB: errSet[ERR_EB_BIT] = 1'b1;
				SRC_FB: errSet[ERR_FB_BIT] = 1'b1;
				SRC_DMA: errSet[ERR_DMA_BIT] = 1'b1;
				default: errSet[ERR_PB_BIT] = 1'b0;
			endcase
			errSet[ERR_TIME_BIT] = errTime;
		end
	end

	// A new error in the same cycle as the clearing read survives the read.
	assign errStatus_nxt = (errRd ? ERR_RESET : errStatus_r) | errSet;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			errStatus_r <= ERR_RESET;
		end else begin
			errStatus_r <= errStatus_nxt;
		end
	end

	// ----------------------------------------------------------------------
	// Error signalling
	// ----------------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			busErrIrq <= 1'b0;
			dmaTimeout <= 1'b0;
		end else begin
			busErrIrq <= errEv && errSrc != SRC_DMA;
			// A DMA write to an 8-bit space is logged but raises no signal here.
			dmaTimeout <= errEv && errTime && errSrc == SRC_DMA;
		end
	end

endmodule : emgsr_core

// ===== bench/emgsr_core_asserts.sv
// Port-level checker for the external memory global status and reset block.
// Assumes it is bound to emgsr_core and sees only that module's ports.
`timescale 1ns/1ns
module emgsr_core_asserts
	import emgsr_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [REG_ADDR_W-1:0] regAddr,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [REG_DATA_W-1:0] regWdata,
	input wire logic [REG_DATA_W-1:0] regRdata,
	input wire logic [NUM_REQ-1:0] pendVec,
	input wire logic extBusReqN,
	input wire logic extBusGrantN,
	input wire logic extStrobe,
	input wire logic busErrIrq,
	input wire logic dmaTimeout
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// ----
	// Helper state
	// ----
	// The request-disable bit is not at the ports, so it is mirrored from writes.
	logic reqDis_r;
	logic reqPrev_r;
	logic [3:0] reqAge_r;
	logic [7:0] strobeCnt_r;
	always_ff @(posedge ref_clk) begin
		if (!nrst)
			reqDis_r <= 1'b0;
		else if (regWrEn && regAddr == GLOBAL_CTRL_IDX)
			reqDis_r <= regWdata[CTRL_REQ_DIS_BIT];
	end
	always_ff @(posedge ref_clk) begin
		reqPrev_r <= extBusReqN;
		if (!nrst || extBusReqN != reqPrev_r)
			reqAge_r <= 4'h0;
		else if (reqAge_r != 4'hF)
			reqAge_r <= reqAge_r + 4'h1;
	end
	always_ff @(posedge ref_clk) begin
		if (!nrst || !extStrobe)
			strobeCnt_r <= 8'h00;
		else if (strobeCnt_r != 8'hFF)
			strobeCnt_r <= strobeCnt_r + 8'h01;
	end
	// ----
	// Properties
	// ----
	a_req_readback: assert property (regRdEn && !regWrEn && regAddr == GLOBAL_CTRL_IDX
		&& reqAge_r >= 4 |=> regRdata[CTRL_REQ_PIN_BIT] == $past(extBusReqN))
		else $error("request pin level not shown in control");
	a_grant_readback: assert property (regRdEn && !regWrEn && regAddr == GLOBAL_CTRL_IDX
		|=> regRdata[CTRL_GRANT_PIN_BIT] == $past(extBusGrantN))
		else $error("grant pin level not shown in control");
	a_grant_blocked: assert property (reqDis_r |=> extBusGrantN)
		else $error("grant given while requests disabled");
	a_soft_clears: assert property (regWrEn && regAddr == SOFT_RESET_IDX
		|=> pendVec == '0 ##1 !extStrobe)
		else $error("soft reset left requests or strobe");
	a_hidden_reads: assert property (regRdEn && !regWrEn
		&& (regAddr == SOFT_RESET_IDX || regAddr == 2'h3) |=> regRdata == 16'h0000)
		else $error("write-only or unmapped read not zero");
	a_strobe_bounded: assert property (strobeCnt_r <= TIMEOUT_CYCLES)
		else $error("strobe outlived the time-out");
	a_dma_no_irq: assert property (dmaTimeout |-> !busErrIrq)
		else $error("DMA time-out also raised CPU interrupt");
	a_grant_idle: assert property (!extBusGrantN |-> !extStrobe)
		else $error("strobe driven while bus granted");
	a_grant_after_req: assert property ($fell(extBusGrantN) |-> !$past(extBusReqN, 3))
		else $error("grant without request");
endmodule : emgsr_core_asserts

bind emgsr_core emgsr_core_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
	.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr), .regWrEn(regWrEn),
	.regRdEn(regRdEn), .regWdata(regWdata), .regRdata(regRdata), .pendVec(pendVec),
	.extBusReqN(extBusReqN), .extBusGrantN(extBusGrantN), .extStrobe(extStrobe),
	.busErrIrq(busErrIrq), .dmaTimeout(dmaTimeout)
);

// ===== bench/emgsr_mem_model.sv
// Far side: an asynchronous memory answering ready, and an outside bus master.
// Assumes ready has a pull-down, so it reads low whenever no access is strobed.
`timescale 1ns/1ns
module emgsr_mem_model (
	input wire logic ref_clk,
	input wire logic extStrobe,
	input wire logic [3:0] readyDelay,
	input wire logic readyOff,
	input wire logic wantBus,
	output logic memReady = 1'b0,
	output logic extBusReqN = 1'b1
);
	logic [3:0] waitCnt = 4'h0;
	// A stuck device is modelled by never raising ready, which forces a time-out.
	always @(posedge ref_clk) begin
		if (!extStrobe) begin
			waitCnt <= 4'h0;
			memReady <= 1'b0;
		end else begin
			if (waitCnt != 4'hF)
				waitCnt <= waitCnt + 4'h1;
			memReady <= !readyOff && waitCnt >= readyDelay;
		end
	end
	always @(posedge ref_clk)
		extBusReqN <= !wantBus;
endmodule : emgsr_mem_model

// ===== bench/emgsr_tb.sv
// Self-checking testbench for the external memory global status and reset block.
// Assumes emgsr_core with a short time-out and the memory model on its far side.
`timescale 1ns/1ns
module tb
	import emgsr_pkg::*;
;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [1:0] regAddr = 2'h0;
	logic regWrEn = 1'b0;
	logic regRdEn = 1'b0;
	logic [15:0] regWdata = 16'h0000;
	logic [15:0] regRdata, cfgBits;
	logic accValid = 1'b0;
	logic [2:0] accSrc = 3'h0;
	logic [1:0] accSpace = 2'h0;
	logic accWrite = 1'b0;
	logic [3:0] space8Async = 4'h0;
	logic [3:0] readyDelay = 4'h2;
	logic readyOff = 1'b0;
	logic wantBus = 1'b0;
	logic irqSeen = 1'b0;
	logic dmaSeen = 1'b0;
	logic errSeen = 1'b0;
	logic [3:0] holdCyc = 4'h3;
	int waitN = 0;
	logic [5:0] pendVec;
	logic [1:0] extSpace;
	logic accRefused, accDone, accErr, extBusGrantN, extStrobe, extWrite, busErrIrq, dmaTimeout;
	logic memReady, extBusReqN;
	int errors = 0;
	int cmp_count = 0;
	int bitOf[6] = '{0, 2, 3, 4, 5, 6};

	emgsr_core #(.TIMEOUT_CYCLES(12)) u_dut (
		.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr), .regWrEn(regWrEn),
		.regRdEn(regRdEn), .regWdata(regWdata), .regRdata(regRdata), .accValid(accValid),
		.accSrc(accSrc), .accSpace(accSpace), .accWrite(accWrite), .pendVec(pendVec),
		.accRefused(accRefused), .accDone(accDone), .accErr(accErr),
		.space8Async(space8Async), .holdCycles(holdCyc), .extBusReqN(extBusReqN),
		.memReady(memReady), .extBusGrantN(extBusGrantN), .extStrobe(extStrobe),
		.extSpace(extSpace), .extWrite(extWrite), .cfgBits(cfgBits), .busErrIrq(busErrIrq),
		.dmaTimeout(dmaTimeout)
	);
	emgsr_mem_model u_mem (
		.ref_clk(ref_clk), .extStrobe(extStrobe), .readyDelay(readyDelay),
		.readyOff(readyOff), .wantBus(wantBus), .memReady(memReady), .extBusReqN(extBusReqN)
	);

	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		if (busErrIrq === 1'b1)
			irqSeen = 1'b1;
		if (dmaTimeout === 1'b1)
			dmaSeen = 1'b1;
		if (accErr === 1'b1)
			errSeen = 1'b1;
	end

	// ----
	// Access tasks
	// ----
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc
	task automatic wr(input logic [1:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWdata <= d;
		regWrEn <= 1'b1;
		@(posedge ref_clk);
		regWrEn <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [1:0] a, input logic [15:0] exp);
		@(posedge ref_clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge ref_clk);
		regRdEn <= 1'b0;
		#1;
		check(regRdata, exp);
	endtask : rd
	task automatic acc(input logic [2:0] s, input logic [1:0] sp, input logic w);
		irqSeen = 1'b0;
		dmaSeen = 1'b0;
		errSeen = 1'b0;
		@(posedge ref_clk);
		accSrc <= s;
		accSpace <= sp;
		accWrite <= w;
		accValid <= 1'b1;
		@(posedge ref_clk);
		accValid <= 1'b0;
		#1;
	endtask : acc
	task automatic wait_done();
		waitN = 0;
		do begin
			cyc(1);
			waitN++;
		end while (accDone !== 1'b1 && waitN < 300);
		check({15'h0000, accDone}, 16'h0001);
	endtask : wait_done
	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish

	initial begin
		#3000000;
		errors++;
		$display("mismatch at %0t: watchdog expired", $time);
		tally_and_finish();
	end

	// ----
	// Test sequence
	// ----
	initial begin
		repeat (16) @(posedge ref_clk);
		nrst <= 1'b1;
		rd(GLOBAL_CTRL_IDX, 16'h0006);
		wr(GLOBAL_CTRL_IDX, 16'h06B1);
		check(cfgBits, 16'h06B0);
		wantBus = 1'b1;
		cyc(8);
		check({15'h0000, extBusGrantN}, 16'h0001);
		rd(GLOBAL_CTRL_IDX, 16'h06B3);
		wr(GLOBAL_CTRL_IDX, 16'h06B0);
		cyc(6);
		check({15'h0000, extBusGrantN}, 16'h0000);
		rd(GLOBAL_CTRL_IDX, 16'h06B0);
		wantBus = 1'b0;
		cyc(6);
		check({15'h0000, extBusGrantN}, 16'h0001);
		rd(SOFT_RESET_IDX, 16'h0000);
		rd(2'h3, 16'h0000);
		acc(SRC_EB, 2'h1, 1'b1);
		cyc(1);
		check({13'h0000, extStrobe, extSpace}, 16'h0005);
		check({15'h0000, extWrite}, 16'h0001);
		wait_done();
		rd(ERR_STATUS_IDX, 16'h0000);
		for (int i = 0; i < 6; i++) begin
			@(posedge ref_clk);
			space8Async <= 4'h1;
			holdCyc <= 4'(2 * i + 1);
			acc(i[2:0], 2'h0, 1'b1);
			wait_done();
			check(16'(waitN), 16'(2 * i + 3));
			check({15'h0000, errSeen}, 16'h0001);
			check({15'h0000, irqSeen}, {15'h0000, i < 5});
			rd(ERR_STATUS_IDX, 16'h0080 | (16'h0001 << bitOf[i]));
		end
		acc(SRC_DB, 2'h0, 1'b1);
		acc(SRC_CB, 2'h0, 1'b1);
		wait_done();
		wait_done();
		rd(ERR_STATUS_IDX, 16'h008C);
		@(posedge ref_clk);
		space8Async <= 4'h2;
		acc(SRC_EB, 2'h1, 1'b1);
		wait_done();
		readyOff = 1'b1;
		acc(SRC_DB, 2'h2, 1'b0);
		wait_done();
		rd(ERR_STATUS_IDX, 16'h1318);
		rd(ERR_STATUS_IDX, 16'h0000);
		acc(SRC_DMA, 2'h3, 1'b0);
		cyc(2);
		acc(SRC_DMA, 2'h3, 1'b0);
		check({10'h000, pendVec}, 16'h0020);
		acc(SRC_DMA, 2'h3, 1'b0);
		check({15'h0000, accRefused}, 16'h0001);
		wait_done();
		check({10'h000, pendVec}, 16'h0000);
		check({14'h0000, dmaSeen, irqSeen}, 16'h0002);
		rd(ERR_STATUS_IDX, 16'h1440);
		acc(SRC_PB, 2'h0, 1'b0);
		cyc(1);
		acc(SRC_CB, 2'h1, 1'b0);
		acc(SRC_FB, 2'h2, 1'b1);
		check({10'h000, pendVec}, 16'h0012);
		wr(SOFT_RESET_IDX, 16'hFFFF);
		cyc(1);
		check({10'h000, pendVec}, 16'h0000);
		check({15'h0000, extStrobe}, 16'h0000);
		check(cfgBits, 16'h06B0);
		rd(GLOBAL_CTRL_IDX, 16'h06B6);
		rd(ERR_STATUS_IDX, 16'h0000);
		tally_and_finish();
	end
endmodule : tb
